//--- inc/cidf_map.vh
`ifndef CIDF_MAP_VH
`define CIDF_MAP_VH
// ==========================================
// register byte offsets
`define CIDF_OFS_CTL0 8'h00
`define CIDF_OFS_CTL1 8'h04
`define CIDF_OFS_BTRA 8'h08
`define CIDF_OFS_BTRB 8'h0C
`define CIDF_OFS_RFLG 8'h10
`define CIDF_OFS_IDAC 8'h14
`define CIDF_OFS_RXERR 8'h18
`define CIDF_OFS_TXERR 8'h1C
`define CIDF_OFS_PAT 8'h20
`define CIDF_OFS_MSK 8'h40
// ==========================================
// field positions
`define CIDF_CTL0_INIT_MODE_REQUEST 0
`define CIDF_CTL1_INIT_MODE_ACKNOWLEDGE 0
`define CIDF_CTL1_CLOCK_SOURCE_SELECT 6
`define CIDF_CTL1_ENABLE 7
`define CIDF_RFLG_FULL 0
`define CIDF_BTRA_PRESC 5:0
`define CIDF_BTRA_SJW 7:6
`define CIDF_BTRB_FIRST_SEGMENT_LENGTH 3:0
`define CIDF_BTRB_SECOND_SEGMENT_LENGTH 6:4
`define CIDF_BTRB_SAM 7
`define CIDF_IDAC_MODE 5:4
`define CIDF_IDAC_HIT 2:0
// ==========================================
// filter modes
`define CIDF_MODE_W32 2'h0
`define CIDF_MODE_W16 2'h1
`define CIDF_MODE_W8 2'h2
`define CIDF_MODE_CLOSED 2'h3
// ==========================================
// reset values and bus answers
`define CIDF_RST_BYTE 8'h00
`define CIDF_RST_CTL0 1'h1
`define CIDF_RESP_OKAY 2'h0
`define CIDF_RESP_SLVERR 2'h2
`endif

//--- rtl/cidf_cmp.v
`default_nettype none
// ==========================================
// one maskable compare slice
module cidf_cmp #(
  parameter W = 8
) (
  input wire [W-1:0] id_bits,
  input wire [W-1:0] pattern,
  input wire [W-1:0] mask,
  output wire hit
);
  // a set mask bit makes that position a don't care
  assign hit = &((~(id_bits ^ pattern)) | mask); // [RULE_01]
endmodule // cidf_cmp
`default_nettype wire

//--- rtl/cidf_top.v
// What this block does
// [RULE_01] masked identifier compare, mask bit means don't care
// [RULE_02] acceptance sets full flag, loads hit index
// [RULE_03] lowest matching filter wins the hit field
// [RULE_04] four modes: two, four, eight, closed
// [RULE_05] two-filter mode compares whole 32-bit identifier
// [RULE_06] bytes 0-3 filter 0, 4-7 filter 1
// [RULE_07] four 16-bit filters, two per bank
// [RULE_08] eight 8-bit filters on first identifier byte
// [RULE_09] closed mode never accepts, never sets full
// [RULE_10] software prefers narrow modes for standard identifiers
// [RULE_11] error counters cannot be written by software
// [RULE_12] config writes only during acknowledged init
// [RULE_13] transmit pin recessive in init or power-down
// [RULE_14] enable bit writable once in normal modes
// [RULE_15] source select picks oscillator or bus clock
// [RULE_16] no clock generator means oscillator source
// [RULE_17] prescaler divides protocol clock into quanta
// [RULE_18] sync segment one quantum, edges expected there
// [RULE_19] first segment four to sixteen quanta
// [RULE_20] second segment two to eight quanta
// [RULE_21] sample at sample point, third of three
// [RULE_22] jump width one to four quanta
// [RULE_23] only valid accepted messages shift to queue
// [RULE_24] length fields hold quanta minus one
`include "cidf_map.vh"
`default_nettype none
module cidf_top #(
  parameter HAS_CLK_GEN = 1
) (
  input wire core_clk,
  input wire reset_n,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // system and protocol engine side
  input wire special_mode,
  input wire power_down,
  input wire osc_clk,
  input wire [7:0] rx_err_count,
  input wire [7:0] tx_err_count,
  input wire [31:0] rx_id_bytes,
  input wire rx_id_valid,
  input wire rx_msg_ok,
  input wire rx_queue_ready,
  input wire tx_bit,
  // bus pins
  input wire receive_pin,
  output reg transmit_pin,
  // results
  output reg rx_shift,
  output reg rx_bit,
  output reg sample_pulse,
  output reg bit_start,
  output reg module_enable
);
  // ==========================================
  // register state
  reg init_req_r; // init_mode_request
  reg init_ack_r; // init_mode_acknowledge
  reg clock_source_select_r; // clock_source_select
  reg enable_written_r; // enable bit already written once
  reg [7:0] btra_r; // bus_timing_reg_a
  reg [7:0] btrb_r; // bus_timing_reg_b
  reg [1:0] mode_r; // acceptance_control_reg mode field
  reg [2:0] hit_r; // filter_hit_indicator
  reg full_r; // receive_full_flag
  reg [7:0] pat_r [0:7]; // acceptance_pattern_regs
  reg [7:0] msk_r [0:7]; // acceptance_mask_regs
  reg aw_hold_r; // write address latched
  reg w_hold_r; // write data latched
  reg [7:0] awaddr_r;
  reg [7:0] wdata_r;
  reg wstrb0_r;
  integer i;
  integer j; // priority scan index, combinational only
  // ==========================================
  // axi4-lite handshake terms
  wire wr_do = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire cfg_open = init_req_r & init_ack_r; // [RULE_12]
  wire wr_pat = (awaddr_r[7:5] == `CIDF_OFS_PAT >> 5);
  wire wr_msk = (awaddr_r[7:5] == `CIDF_OFS_MSK >> 5);
  wire wr_lane = wr_do & wstrb0_r;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // mapped write address check
  reg wr_map;
  always @* begin
    case (awaddr_r)
      `CIDF_OFS_CTL0, `CIDF_OFS_CTL1, `CIDF_OFS_BTRA, `CIDF_OFS_BTRB,
      `CIDF_OFS_RFLG, `CIDF_OFS_IDAC, `CIDF_OFS_RXERR, `CIDF_OFS_TXERR: begin
        wr_map = 1'b1;
      end
      default: begin
        wr_map = (wr_pat | wr_msk) & (awaddr_r[1:0] == 2'h0);
      end
    endcase
  end
  // ==========================================
  // write channel: address and data in either order
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= `CIDF_RST_BYTE;
      wdata_r <= `CIDF_RST_BYTE;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIDF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        // response once both halves are in
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `CIDF_RESP_OKAY : `CIDF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================
  // control and configuration registers
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_req_r <= `CIDF_RST_CTL0;
      init_ack_r <= 1'b0;
      clock_source_select_r <= 1'b0;
      module_enable <= 1'b0;
      enable_written_r <= 1'b0;
      btra_r <= `CIDF_RST_BYTE;
      btrb_r <= `CIDF_RST_BYTE;
      mode_r <= `CIDF_MODE_W32;
      for (i = 0; i < 8; i = i + 1) begin
        pat_r[i] <= `CIDF_RST_BYTE;
        msk_r[i] <= `CIDF_RST_BYTE;
      end
    end else begin
      // acknowledge follows the request one cycle later
      init_ack_r <= init_req_r;
      if (wr_lane && awaddr_r == `CIDF_OFS_CTL0) init_req_r <= wdata_r[`CIDF_CTL0_INIT_MODE_REQUEST];
      if (wr_lane && awaddr_r == `CIDF_OFS_CTL1) begin
        // enable is not under the init lock
        if (special_mode | ~enable_written_r) begin
          module_enable <= wdata_r[`CIDF_CTL1_ENABLE]; // [RULE_14]
          enable_written_r <= 1'b1; // [RULE_14]
        end
        if (cfg_open) clock_source_select_r <= wdata_r[`CIDF_CTL1_CLOCK_SOURCE_SELECT]; // [RULE_12]
      end
      if (wr_lane & cfg_open) begin
        // locked group: timing, acceptance, patterns, masks
        if (awaddr_r == `CIDF_OFS_BTRA) btra_r <= wdata_r; // [RULE_12]
        if (awaddr_r == `CIDF_OFS_BTRB) btrb_r <= wdata_r; // [RULE_12]
        if (awaddr_r == `CIDF_OFS_IDAC) mode_r <= wdata_r[`CIDF_IDAC_MODE]; // [RULE_04] [RULE_12]
        if (wr_pat & (awaddr_r[1:0] == 2'h0)) pat_r[awaddr_r[4:2]] <= wdata_r; // [RULE_12]
        if (wr_msk & (awaddr_r[1:0] == 2'h0)) msk_r[awaddr_r[4:2]] <= wdata_r; // [RULE_12]
      end
    end
  end
  // ==========================================
  // read channel
  reg [7:0] rd_byte;
  reg rd_map;
  always @* begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      `CIDF_OFS_CTL0: rd_byte = {7'h00, init_req_r};
      `CIDF_OFS_CTL1: rd_byte = {module_enable, clock_source_select_r, 5'h00, init_ack_r};
      `CIDF_OFS_BTRA: rd_byte = btra_r;
      `CIDF_OFS_BTRB: rd_byte = btrb_r;
      `CIDF_OFS_RFLG: rd_byte = {7'h00, full_r};
      `CIDF_OFS_IDAC: rd_byte = {2'h0, mode_r, 1'b0, hit_r};
      // counters are read-only, writes have no path to them
      `CIDF_OFS_RXERR: rd_byte = rx_err_count; // [RULE_11]
      `CIDF_OFS_TXERR: rd_byte = tx_err_count; // [RULE_11]
      default: begin
        if (s_axi_araddr[1:0] != 2'h0) begin
          rd_byte = 8'h00;
          rd_map = 1'b0;
        end else if (s_axi_araddr[7:5] == `CIDF_OFS_PAT >> 5) begin
          rd_byte = pat_r[s_axi_araddr[4:2]];
        end else if (s_axi_araddr[7:5] == `CIDF_OFS_MSK >> 5) begin
          rd_byte = msk_r[s_axi_araddr[4:2]];
        end else begin
          rd_byte = 8'h00;
          rd_map = 1'b0;
        end
      end
    endcase
  end
  // registered read answer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CIDF_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_map ? `CIDF_RESP_OKAY : `CIDF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ==========================================
  // acceptance filter slices
  wire [63:0] pat_all;
  wire [63:0] msk_all;
  wire [1:0] hit32;
  wire [3:0] hit16;
  wire [7:0] hit8;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flat
      // byte 0 sits at the top, as in the identifier layout
      assign pat_all[63-8*g -: 8] = pat_r[g];
      assign msk_all[63-8*g -: 8] = msk_r[g];
      cidf_cmp #(.W(8)) u_c8 (
        .id_bits(rx_id_bytes[31:24]),
        .pattern(pat_all[63-8*g -: 8]),
        .mask(msk_all[63-8*g -: 8]),
        .hit(hit8[g])
      ); // [RULE_08]
    end
    for (g = 0; g < 4; g = g + 1) begin : g_w16
      cidf_cmp #(.W(16)) u_c16 (
        .id_bits(rx_id_bytes[31:16]),
        .pattern(pat_all[63-16*g -: 16]),
        .mask(msk_all[63-16*g -: 16]),
        .hit(hit16[g])
      ); // [RULE_07]
    end
    for (g = 0; g < 2; g = g + 1) begin : g_w32
      cidf_cmp #(.W(32)) u_c32 (
        .id_bits(rx_id_bytes),
        .pattern(pat_all[63-32*g -: 32]),
        .mask(msk_all[63-32*g -: 32]),
        .hit(hit32[g])
      ); // [RULE_05] [RULE_06]
    end
  endgenerate
  // mode select and lowest-index priority
  reg [7:0] hit_vec;
  reg [2:0] hit_idx;
  always @* begin
    case (mode_r)
      `CIDF_MODE_W32: hit_vec = {6'h00, hit32}; // [RULE_04]
      `CIDF_MODE_W16: hit_vec = {4'h0, hit16}; // [RULE_04]
      `CIDF_MODE_W8: hit_vec = hit8; // [RULE_04]
      default: hit_vec = 8'h00; // [RULE_09]
    endcase
    hit_idx = 3'h0;
    for (j = 7; j >= 0; j = j - 1) begin
      if (hit_vec[j]) hit_idx = j[2:0]; // [RULE_03]
    end
  end
  // ==========================================
  // acceptance result and receive flag
  reg acc_r; // current frame accepted
  reg [2:0] acc_idx_r;
  wire shift_now = rx_msg_ok & acc_r & rx_queue_ready; // [RULE_23]
  wire full_clr = wr_lane & (awaddr_r == `CIDF_OFS_RFLG) & wdata_r[`CIDF_RFLG_FULL];
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 1'b0;
      acc_idx_r <= 3'h0;
      hit_r <= 3'h0;
      full_r <= 1'b0;
      rx_shift <= 1'b0;
    end else begin
      if (rx_id_valid) begin
        // closed mode leaves hit_vec empty
        acc_r <= |hit_vec; // [RULE_09]
        acc_idx_r <= hit_idx;
      end else if (rx_msg_ok) begin
        acc_r <= 1'b0;
      end
      rx_shift <= shift_now; // [RULE_23]
      if (shift_now) begin
        hit_r <= acc_idx_r; // [RULE_02]
      end
      // write-one-to-clear, a new set wins
      full_r <= shift_now | (full_r & ~full_clr); // [RULE_02]
    end
  end
  // ==========================================
  // pin synchronisers and protocol clock tick
  reg osc_s1_r, osc_s2_r, osc_s3_r;
  reg rx_s1_r, rx_s2_r, rx_s3_r;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      osc_s1_r <= osc_clk;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      rx_s1_r <= receive_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end
  wire use_bus_clk = clock_source_select_r & (HAS_CLK_GEN != 0); // [RULE_15] [RULE_16]
  wire pclk_tick = use_bus_clk | (osc_s2_r & ~osc_s3_r); // [RULE_15]
  wire run = module_enable & ~init_ack_r & ~power_down;
  wire rx_fall = rx_s3_r & ~rx_s2_r; // recessive to dominant
  // ==========================================
  // prescaler and bit timing
  localparam PH_SYNC = 2'h0;
  localparam PH_SEG1 = 2'h1;
  localparam PH_SEG2 = 2'h2;
  reg [5:0] pre_cnt_r;
  reg [1:0] phase_r;
  reg [4:0] qcnt_r; // quanta spent in segment
  reg [2:0] ext_r; // seg1 lengthening
  reg edge_r; // edge seen this quantum
  reg [2:0] samp_r; // last three quantum samples
  wire q_tick = run & pclk_tick & (pre_cnt_r == btra_r[`CIDF_BTRA_PRESC]); // [RULE_17]
  wire [4:0] sjw_q = {3'h0, btra_r[`CIDF_BTRA_SJW]} + 5'h01; // [RULE_22] [RULE_24]
  wire [4:0] seg1_q = {1'b0, btrb_r[`CIDF_BTRB_FIRST_SEGMENT_LENGTH]} + 5'h01 + {2'h0, ext_r}; // [RULE_19]
  wire [4:0] seg2_q = {2'h0, btrb_r[`CIDF_BTRB_SECOND_SEGMENT_LENGTH]} + 5'h01; // [RULE_20] [RULE_24]
  wire [4:0] qnext = qcnt_r + 5'h01;
  wire [4:0] seg2_left = seg2_q - qcnt_r;
  wire maj = (samp_r[0] & samp_r[1]) | (samp_r[0] & rx_s2_r) | (samp_r[1] & rx_s2_r);
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_r <= 6'h00;
      phase_r <= PH_SYNC;
      qcnt_r <= 5'h00;
      ext_r <= 3'h0;
      edge_r <= 1'b0;
      samp_r <= 3'h7;
      rx_bit <= 1'b1;
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
    end else begin
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
      if (!run) begin
        // timing restarts cleanly after init
        pre_cnt_r <= 6'h00;
        phase_r <= PH_SYNC;
        qcnt_r <= 5'h00;
        ext_r <= 3'h0;
        edge_r <= 1'b0;
      end else begin
        if (pclk_tick) begin
          pre_cnt_r <= q_tick ? 6'h00 : pre_cnt_r + 6'h01; // [RULE_17]
        end
        if (rx_fall) begin
          edge_r <= 1'b1;
        end
        if (q_tick) begin
          edge_r <= rx_fall;
          samp_r <= {samp_r[1:0], rx_s2_r};
          case (phase_r)
            PH_SYNC: begin
              // single quantum, edges expected here
              phase_r <= PH_SEG1; // [RULE_18]
              qcnt_r <= 5'h00;
              ext_r <= 3'h0;
              bit_start <= 1'b1;
            end
            PH_SEG1: begin
              if (edge_r & (ext_r == 3'h0)) begin
                // late edge lengthens seg1 by at most the jump width
                ext_r <= (qnext > sjw_q) ? sjw_q[2:0] : qnext[2:0]; // [RULE_22]
              end
              if (qnext >= seg1_q) begin
                phase_r <= PH_SEG2;
                qcnt_r <= 5'h00;
                sample_pulse <= 1'b1; // [RULE_21]
                rx_bit <= btrb_r[`CIDF_BTRB_SAM] ? maj : rx_s2_r; // [RULE_21]
              end else begin
                qcnt_r <= qnext;
              end
            end
            PH_SEG2: begin
              if (edge_r & (seg2_left <= sjw_q)) begin
                // early edge: it was the next sync quantum
                phase_r <= PH_SEG1; // [RULE_22]
                qcnt_r <= 5'h00;
                ext_r <= 3'h0;
                bit_start <= 1'b1;
              end else if (edge_r) begin
                qcnt_r <= qcnt_r + sjw_q; // [RULE_22]
              end else if (qnext >= seg2_q) begin
                phase_r <= PH_SYNC; // [RULE_18]
                qcnt_r <= 5'h00;
              end else begin
                qcnt_r <= qnext;
              end
            end
            default: begin
              phase_r <= PH_SYNC;
            end
          endcase
        end
      end
    end
  end
  // ==========================================
  // transmit pin forcing
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      transmit_pin <= 1'b1;
    end else begin
      transmit_pin <= (init_req_r | init_ack_r | power_down) ? 1'b1 : tx_bit; // [RULE_13]
    end
  end
endmodule // cidf_top
`default_nettype wire

//--- test/cidf_top_properties.sv
`default_nettype none
// ==========================================
// port checker for the filter and bit timing block
module cidf_top_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic special_mode,
  input wire logic power_down,
  input wire logic rx_msg_ok,
  input wire logic rx_queue_ready,
  input wire logic transmit_pin,
  input wire logic rx_shift,
  input wire logic rx_bit,
  input wire logic sample_pulse,
  input wire logic bit_start,
  input wire logic module_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // steps
  // both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // no complete message for the queue
  sequence s_no_msg;
    !(rx_msg_ok && rx_queue_ready);
  endsequence
  // power-down seen on two edges
  sequence s_pd_held;
    power_down ##1 power_down;
  endsequence
  // ==========================================
  // checks
  chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_txd_recessive: assert property (power_down |=> transmit_pin)
    else $error("transmit pin dominant in power-down");
  chk_shift_cause: assert property (not (s_no_msg ##1 rx_shift))
    else $error("shift without valid message");
  chk_enable_sticky: assert property (module_enable && !special_mode |=> module_enable)
    else $error("enable cleared in normal mode");
  chk_sync_nosample: assert property (bit_start |-> !sample_pulse)
    else $error("sample inside sync segment");
  chk_rxbit_sample: assert property ($changed(rx_bit) |-> sample_pulse)
    else $error("received bit changed off sample point");
  chk_pd_halt: assert property (s_pd_held |-> !bit_start && !sample_pulse)
    else $error("timing runs in power-down");
endmodule // cidf_top_properties

bind cidf_top cidf_top_properties cidf_top_properties_inst (.*);
`default_nettype wire

//--- test/cidf_can_node.sv
`default_nettype none
// ==========================================
// far bus node and receive engine stand-in
module cidf_can_node (
  input wire logic core_clk,
  input wire logic transmit_pin,
  output logic receive_pin,
  output logic [31:0] rx_id_bytes,
  output logic rx_id_valid,
  output logic rx_msg_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] node_cnt = 4'h0; // other node bit pattern
  initial begin
    rx_id_bytes = 32'h00000000;
    rx_id_valid = 1'h0;
    rx_msg_ok = 1'h0;
  end
  // other node alternates dominant and recessive runs
  always @(posedge core_clk) begin
    node_cnt <= node_cnt + 4'h1;
  end
  // wired-and bus, dominant low
  assign receive_pin = transmit_pin & ~node_cnt[3];
  // one frame: identifier, then end-of-frame verdict
  task send(input logic [31:0] id, input logic ok);
    @(posedge core_clk);
    rx_id_bytes <= id;
    rx_id_valid <= 1'h1;
    @(posedge core_clk);
    rx_id_valid <= 1'h0;
    rx_id_bytes <= ~id; // released bytes no longer hold the id
    rx_msg_ok <= ok;
    @(posedge core_clk);
    rx_msg_ok <= 1'h0;
  endtask
endmodule // cidf_can_node
`default_nettype wire

//--- test/test_can_id_filter_bit_timing.sv
`include "cidf_map.vh"
`default_nettype none
module test_can_id_filter_bit_timing;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // stimulus and observed signals
  logic core_clk = 1'h0;
  logic osc_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF; // full word strobes
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic special_mode = 1'h0, power_down = 1'h0, rx_queue_ready = 1'h1, tx_bit = 1'h0;
  logic [7:0] rx_err_count = 8'h5A, tx_err_count = 8'hA5;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rx_id_bytes;
  logic rx_id_valid, rx_msg_ok, receive_pin, transmit_pin, rx_shift, rx_bit;
  logic sample_pulse, bit_start, module_enable;
  int n_fail = 0, checks = 0, n_shift = 0, n, i;
  logic [7:0] pat [8] = '{8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h32, 8'h87};
  // ==========================================
  // clocks, instances, shift monitor
  always #10 core_clk = ~core_clk;
  // oscillator, three core cycles, offset phase
  initial begin
    #7;
    forever #30 osc_clk = ~osc_clk;
  end
  cidf_top #(.HAS_CLK_GEN(1)) cidf_top_inst (.*);
  cidf_can_node cidf_can_node_inst (.*);
  // count messages shifted to the queue
  always @(posedge core_clk) begin
    if (rx_shift === 1'h1) n_shift <= n_shift + 1;
  end
  // ==========================================
  // helpers
  task finish_test();
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // compare and report
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // a wait ran out
  task tmo();
    chk("wait_done", 32'h1, 32'h0);
    finish_test();
  endtask
  // bus write, response 3 means any
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    if (k == 50) tmo();
    if (er !== 2'h3) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // bus read and compare, data only when okay
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    if (k == 50) tmo();
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (er === `CIDF_RESP_OKAY) chk(nm, e, s_axi_rdata);
  endtask
  // configure inside init, then go on-line
  task cfg(input logic [7:0] c1, input logic [7:0] ba, input logic [7:0] bb,
           input logic [1:0] md);
    wr(`CIDF_OFS_CTL0, 8'h01, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_CTL1, c1, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_BTRA, ba, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_BTRB, bb, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_IDAC, {2'h0, md, 4'h0}, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_CTL0, 8'h00, `CIDF_RESP_OKAY);
  endtask
  // edges until the next bit start
  task wbit(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (bit_start !== 1'h1 && c < 300);
    if (c >= 300) tmo();
  endtask
  // one frame, then shift count, flag, hit field
  task flt(input logic [31:0] id, input logic ok, input logic qr, input logic acc,
           input logic [2:0] hit, input logic [1:0] md);
    int s0;
    rx_queue_ready <= qr;
    s0 = n_shift;
    cidf_can_node_inst.send(id, ok);
    repeat (2) @(posedge core_clk);
    chk("shift_count", {31'h0, acc}, 32'(n_shift - s0));
    rchk("full_flag", `CIDF_OFS_RFLG, {31'h0, acc}, `CIDF_RESP_OKAY);
    if (acc) rchk("hit_field", `CIDF_OFS_IDAC, {26'h0, md, 1'h0, hit}, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_RFLG, 8'h01, `CIDF_RESP_OKAY);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
    chk("txpin_init", 32'h1, {31'h0, transmit_pin});
    rchk("ctl0", `CIDF_OFS_CTL0, 32'h1, `CIDF_RESP_OKAY);
    rchk("init_ack", `CIDF_OFS_CTL1, 32'h1, `CIDF_RESP_OKAY);
    rchk("unmapped", 8'h60, 32'h0, `CIDF_RESP_SLVERR);
    wr(8'h62, 8'h00, `CIDF_RESP_SLVERR);
    wr(`CIDF_OFS_RXERR, 8'hFF, 2'h3);
    wr(`CIDF_OFS_TXERR, 8'h00, 2'h3);
    rchk("rx_err", `CIDF_OFS_RXERR, 32'h5A, `CIDF_RESP_OKAY);
    rchk("tx_err", `CIDF_OFS_TXERR, 32'hA5, `CIDF_RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      wr(8'(`CIDF_OFS_PAT + 4 * i), pat[i], `CIDF_RESP_OKAY);
      wr(8'(`CIDF_OFS_MSK + 4 * i), (i == 7) ? 8'h0F : 8'h00, `CIDF_RESP_OKAY);
    end
    // bit length: bus clock, long segments, oscillator
    cfg(8'hC0, 8'h00, 8'h13, `CIDF_MODE_W32);
    repeat (3) wbit(n); // first bit may carry the leave-init edge
    chk("bit_len_a", 32'd7, 32'(n));
    cfg(8'hC0, 8'h41, 8'h7F, `CIDF_MODE_W32);
    repeat (3) wbit(n);
    chk("bit_len_b", 32'd50, 32'(n));
    cfg(8'h80, 8'h00, 8'h13, `CIDF_MODE_W32);
    repeat (3) wbit(n);
    chk("bit_len_osc", 32'd21, 32'(n));
    // on-line: configuration locked, enable write-once
    wr(`CIDF_OFS_PAT, 8'hFF, 2'h3);
    rchk("pat_lock", `CIDF_OFS_PAT, 32'h10, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_BTRB, 8'h00, 2'h3);
    rchk("btrb_lock", `CIDF_OFS_BTRB, 32'h13, `CIDF_RESP_OKAY);
    wr(`CIDF_OFS_CTL1, 8'h00, 2'h3);
    chk("enable_kept", 32'h1, {31'h0, module_enable});
    special_mode <= 1'h1;
    wr(`CIDF_OFS_CTL1, 8'h00, 2'h3);
    chk("enable_special", 32'h0, {31'h0, module_enable});
    wr(`CIDF_OFS_CTL1, 8'h80, 2'h3);
    special_mode <= 1'h0;
    power_down <= 1'h1;
    repeat (4) @(posedge core_clk);
    chk("txpin_pd", 32'h1, {31'h0, transmit_pin});
    power_down <= 1'h0;
    // filter modes
    cfg(8'hC0, 8'h00, 8'h13, `CIDF_MODE_W32);
    flt(32'h10213243, 1'h1, 1'h1, 1'h1, 3'h0, `CIDF_MODE_W32);
    flt(32'h5465328E, 1'h1, 1'h1, 1'h1, 3'h1, `CIDF_MODE_W32);
    flt(32'h5465324E, 1'h1, 1'h1, 1'h0, 3'h0, `CIDF_MODE_W32);
    flt(32'h10213243, 1'h0, 1'h1, 1'h0, 3'h0, `CIDF_MODE_W32);
    flt(32'h10213243, 1'h1, 1'h0, 1'h0, 3'h0, `CIDF_MODE_W32);
    cfg(8'hC0, 8'h00, 8'h13, `CIDF_MODE_W16);
    flt(32'h32430000, 1'h1, 1'h1, 1'h1, 3'h1, `CIDF_MODE_W16);
    flt(32'h54650000, 1'h1, 1'h1, 1'h1, 3'h2, `CIDF_MODE_W16);
    cfg(8'hC0, 8'h00, 8'h13, `CIDF_MODE_W8);
    flt(32'h32FFFFFF, 1'h1, 1'h1, 1'h1, 3'h2, `CIDF_MODE_W8);
    flt(32'h8C000000, 1'h1, 1'h1, 1'h1, 3'h7, `CIDF_MODE_W8);
    cfg(8'hC0, 8'h00, 8'h13, `CIDF_MODE_CLOSED);
    flt(32'h10213243, 1'h1, 1'h1, 1'h0, 3'h0, `CIDF_MODE_CLOSED);
    flt(32'h8C000000, 1'h1, 1'h1, 1'h0, 3'h0, `CIDF_MODE_CLOSED);
    finish_test();
  end
endmodule // test_can_id_filter_bit_timing
`default_nettype wire
